// [src/pwmc_consts.vh]
/*
 * Constants for the four-channel 8-bit PWM block: register word indexes,
 * field positions, reset values and the counter clear value.
 * Assumes it is included by bare name from the PWM design file.
 */
`ifndef PWMC_CONSTS_VH
`define PWMC_CONSTS_VH

// Register word indexes; byte address is four times the index
`define PWMC_IDX_POL      8'h61
`define PWMC_IDX_EN       8'h63
`define PWMC_IDX_CNT1     8'h64
`define PWMC_IDX_CNT2     8'h65
`define PWMC_IDX_CNT3     8'h66
`define PWMC_IDX_CNT4     8'h67
`define PWMC_IDX_PER1     8'h68
`define PWMC_IDX_PER2     8'h69
`define PWMC_IDX_PER3     8'h6a
`define PWMC_IDX_PER4     8'h6b
`define PWMC_IDX_DTY1     8'h6c
`define PWMC_IDX_DTY2     8'h6d
`define PWMC_IDX_DTY3     8'h6e
`define PWMC_IDX_DTY4     8'h6f

// Field positions in the control words
`define PWMC_POL_LSB      0
`define PWMC_EN_LSB       0

// Reset values
`define PWMC_RST_CNT      8'h00
`define PWMC_RST_PER      8'hff
`define PWMC_RST_DTY      8'hff
`define PWMC_RST_POL      4'h0
`define PWMC_RST_EN       4'h0

// Counter clear value
`define PWMC_CNT_ZERO     8'h00

`endif

// [src/pwmc_core.v]
/*
 * Four-channel 8-bit PWM core: per-channel counter, period register with
 * a shadow buffer, duty register with a shadow buffer, polarity and
 * enable control, all reached over an APB slave port.
 * Assumes chan_tick comes from a prescaler on the same pclk (one-cycle
 * pulses, no synchronising needed) and that the port logic outside
 * turns pwm_oe_n into the real pin drive.
 * Assumes an APB master with the usual setup and access phases; the
 * slave answers with no wait state.
 */
//
// Behaviour
// - Counter reads return the live count and disturb nothing.
// - Any counter write clears that counter to zero, whatever the data.
// - Counter writes are taken enabled or not and restart the period.
// - Compare uses a period buffer loaded whenever the counter clears.
// - Period writes are allowed anytime and act from the next counter clear on.
// - Period and duty reads return the last written value.
// - On a duty match the output takes the polarity-defined level.
// - Duty writes while enabled wait in a buffer until rollover or disable.
// - Duty at or above period: no match edge; output equals polarity.
// - Duty zero, period nonzero: output stays in its post-match level.
// - Period zero: output constant low, or high with polarity set.
// - Polarity set starts high then low; clear starts low then high.
// - Enable gates ticks at a clock edge and forces the pin to output.
// - The period ends on a counter-period match, counter restarts at 0.
`timescale 1ns/1ps
`include "pwmc_consts.vh"

// Register map: word index, byte address (four times the index)
//   0x61  0x184  output_polarity, one bit per channel
//   0x63  0x18c  channel_enable, one bit per channel
//   0x64  0x190  channel1_counter
//   0x65  0x194  channel2_counter
//   0x66  0x198  channel3_counter
//   0x67  0x19c  channel4_counter
//   0x68  0x1a0  channel1_period
//   0x69  0x1a4  channel2_period
//   0x6a  0x1a8  channel3_period
//   0x6b  0x1ac  channel4_period
//   0x6c  0x1b0  channel1_duty
//   0x6d  0x1b4  channel2_duty
//   0x6e  0x1b8  channel3_duty
//   0x6f  0x1bc  channel4_duty
// Other word indexes answer with pslverr and read as zero

module pwmc_core
#(
   parameter ADDR_W = 12,
   parameter NCH    = 4
)
(
   // Clock and reset
   input  wire              pclk,
   input  wire              presetn,
   // APB slave
   input  wire              psel,
   input  wire              penable,
   input  wire              pwrite,
   input  wire [ADDR_W-1:0] paddr,
   input  wire [31:0]       pwdata,
   output reg  [31:0]       prdata,
   output wire              pready,
   output wire              pslverr,
   // Channel clock ticks from the prescaler
   input  wire [NCH-1:0]    chan_tick,
   // PWM pins
   output wire [NCH-1:0]    pwm_out,
   output wire [NCH-1:0]    pwm_oe_n
);

   // Word index of the current APB address
   wire [7:0]        word_idx;
   wire              addr_ok;
   wire              wr_acc;
   wire              rd_setup;

   // Software-visible control
   reg  [NCH-1:0]    output_polarity;
   reg  [NCH-1:0]    channel_enable;
   // Enable as seen by the channels, taken at a clock edge
   reg  [NCH-1:0]    en_act;

   // Per-channel read words and hits, merged by the read decode
   wire [32*NCH-1:0] ch_rdata;
   wire [NCH-1:0]    ch_hit;
   // Registered pin levels, one bit per channel
   wire [NCH-1:0]    lvl;
   // Loop index of the read merge
   integer           ri;

   // Decoded read data and hit flag
   reg  [31:0]       next_prdata;
   reg               hit;

   assign word_idx = paddr[9:2];
   assign addr_ok  = (paddr[1:0] == 2'b00) && (paddr[ADDR_W-1:10] == 0);
   assign wr_acc   = psel && penable && pwrite;
   assign rd_setup = psel && !penable && !pwrite;

   // Zero wait states: the answer comes in the first access cycle
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !hit;

   // Pin drives while enabled, regardless of the port direction bit
   assign pwm_oe_n = ~en_act;
   assign pwm_out  = lvl;

   // Control registers for polarity and enable
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         output_polarity <= `PWMC_RST_POL;
         channel_enable  <= `PWMC_RST_EN;
         en_act          <= `PWMC_RST_EN;
      end
      else
      begin
         // Polarity acts at once; it is not buffered
         if (wr_acc && hit && word_idx == `PWMC_IDX_POL)
         begin
            output_polarity <= pwdata[`PWMC_POL_LSB +: NCH];
         end
         // A stopped channel keeps its counter; only the ticks stop
         if (wr_acc && hit && word_idx == `PWMC_IDX_EN)
         begin
            channel_enable <= pwdata[`PWMC_EN_LSB +: NCH];
         end
         // Enable reaches the channel only at an edge, no glitch
         en_act <= channel_enable;
      end
   end

   // Channel timing, ticks on every pclk, period 3, duty 1, polarity 0:
   //   counter 0 1 2 3 0 1 ...   (period + 1 ticks per waveform)
   //   pin     - 0 1 1 1 0 ...   (one pclk behind the counter)
   // Period and duty buffers reload together whenever the counter
   // clears, so a period and duty pair written between two clears
   // takes effect as a pair while the channel is enabled.
   // Hazard: a duty write while enabled is invisible on the pin until
   // the next clear, which may be up to 256 ticks away.

   genvar gi;
   generate
      for (gi = 0; gi < NCH; gi = gi + 1)
      begin : g_ch
         reg  [7:0] channel_counter;
         reg  [7:0] channel_period;
         reg  [7:0] channel_duty;
         reg  [7:0] per_buf;
         reg  [7:0] dty_buf;
         reg        next_lvl;
         wire       pol;
         wire       tick;
         wire       per_hit;
         wire       cnt_wr;
         wire       per_wr;
         wire       dty_wr;
         wire [7:0] cnt_idx;
         wire [7:0] per_idx;
         wire [7:0] dty_idx;
         wire       cnt_rd;
         wire       per_rd;
         wire       dty_rd;
         wire       per_zero;
         wire       dty_zero;
         wire       dty_over;
         wire       past_dty;
         reg        lvl_q;
         // Channel number as an 8-bit offset for the index sums
         localparam [7:0] CH_OFS = gi;

         // Word indexes of this channel's three registers
         assign cnt_idx = `PWMC_IDX_CNT1 + CH_OFS;
         assign per_idx = `PWMC_IDX_PER1 + CH_OFS;
         assign dty_idx = `PWMC_IDX_DTY1 + CH_OFS;
         // Read selects; a write is the same select in a write access
         assign cnt_rd  = addr_ok && word_idx == cnt_idx;
         assign per_rd  = addr_ok && word_idx == per_idx;
         assign dty_rd  = addr_ok && word_idx == dty_idx;
         assign cnt_wr  = wr_acc && cnt_rd;
         assign per_wr  = wr_acc && per_rd;
         assign dty_wr  = wr_acc && dty_rd;
         assign pol     = output_polarity[gi];
         // Disabled channel sees no tick at all
         assign tick    = en_act[gi] && chan_tick[gi];
         assign per_hit = (channel_counter == per_buf);
         // Boundary flags of the active buffers, in priority order
         assign per_zero = (per_buf == `PWMC_CNT_ZERO);
         assign dty_zero = (dty_buf == `PWMC_CNT_ZERO);
         assign dty_over = (dty_buf >= per_buf);
         assign past_dty = (channel_counter >= dty_buf);

         // Software copies; reads return these, not the buffers
         always @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               channel_period <= `PWMC_RST_PER;
               channel_duty   <= `PWMC_RST_DTY;
            end
            else
            begin
               if (per_wr)
               begin
                  channel_period <= pwdata[7:0];
               end
               if (dty_wr)
               begin
                  channel_duty <= pwdata[7:0];
               end
            end
         end

         // Counter and shadow buffers
         always @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               channel_counter <= `PWMC_RST_CNT;
               per_buf         <= `PWMC_RST_PER;
               dty_buf         <= `PWMC_RST_DTY;
            end
            else if (cnt_wr)
            begin
               // Data is ignored; clearing mid-period may cut it short
               channel_counter <= `PWMC_CNT_ZERO;
               per_buf         <= channel_period;
               dty_buf         <= channel_duty;
            end
            else if (tick && per_hit)
            begin
               channel_counter <= `PWMC_CNT_ZERO;
               per_buf         <= channel_period;
               dty_buf         <= channel_duty;
            end
            else
            begin
               if (tick)
               begin
                  channel_counter <= channel_counter + 8'h01;
               end
               // A stopped channel follows the duty register at once
               if (!en_act[gi])
               begin
                  dty_buf <= channel_duty;
               end
            end
         end

         // Output level from the active buffers and the polarity
         always @*
         begin
            if (per_zero)
            begin
               // Period zero wins over every other case
               next_lvl = pol;
            end
            else if (dty_zero)
            begin
               next_lvl = !pol;
            end
            else if (dty_over)
            begin
               // The match never comes, so the start level stays
               next_lvl = pol;
            end
            else if (past_dty)
            begin
               next_lvl = !pol;
            end
            else
            begin
               next_lvl = pol;
            end
         end

         // Registered pin level, one pclk behind the counter
         always @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               lvl_q <= 1'b0;
            end
            else
            begin
               lvl_q <= next_lvl;
            end
         end
         assign lvl[gi] = lvl_q;

         // This channel's share of the read mux; zero when not addressed
         assign ch_hit[gi] = cnt_rd || per_rd || dty_rd;
         assign ch_rdata[32*gi +: 32] =
            cnt_rd ? {24'h00_0000, channel_counter} :
            per_rd ? {24'h00_0000, channel_period}  :
            dty_rd ? {24'h00_0000, channel_duty}    :
                     32'h0000_0000;
      end
   endgenerate

   // Read decode; also flags unmapped addresses for pslverr
   always @*
   begin
      next_prdata = 32'h0000_0000;
      hit         = 1'b0;
      if (addr_ok && word_idx == `PWMC_IDX_POL)
      begin
         next_prdata = {{(32-NCH){1'b0}}, output_polarity};
         hit         = 1'b1;
      end
      else if (addr_ok && word_idx == `PWMC_IDX_EN)
      begin
         next_prdata = {{(32-NCH){1'b0}}, channel_enable};
         hit         = 1'b1;
      end
      else
      begin
         // At most one channel answers, so OR-ing acts as a select
         for (ri = 0; ri < NCH; ri = ri + 1)
         begin
            next_prdata = next_prdata | ch_rdata[32*ri +: 32];
            hit         = hit | ch_hit[ri];
         end
      end
   end

   // Read data captured in the setup cycle, held through the access
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= 32'h0000_0000;
      end
      else if (rd_setup)
      begin
         // Held after the setup cycle, so the access edge sees it
         prdata <= next_prdata;
      end
   end

endmodule // pwmc_core

// [tb/pwmc_core_chk.sv]
/* Port checker for the PWM core.
   Assumes zero wait states, byte address four times the index. */
`timescale 1ns/1ps
module pwmc_core_chk
#(
   parameter ADDR_W = 12,
   parameter NCH    = 4
)
(
   // Clock and reset
   input wire              pclk,
   input wire              presetn,
   // APB
   input wire              psel,
   input wire              penable,
   input wire              pwrite,
   input wire [ADDR_W-1:0] paddr,
   input wire [31:0]       pwdata,
   input wire [31:0]       prdata,
   input wire              pready,
   input wire              pslverr,
   // Channels
   input wire [NCH-1:0]    chan_tick,
   input wire [NCH-1:0]    pwm_out,
   input wire [NCH-1:0]    pwm_oe_n
);
   // Bus phase decode
   wire acc = psel && penable;
   wire wr  = acc && pwrite;
   wire rs  = psel && !penable && !pwrite;
   wire bad = paddr[1:0] != 2'b00;
   wire cw  = wr && !bad && paddr >= 'h190 && paddr < 'h1a0;
   wire pw  = wr && !bad && paddr >= 'h1a0 && paddr < 'h1c0;
   wire ew  = wr && paddr == 'h18c;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   rdy_high_a: assert property (pready)
      else $error("no ready");
   err_acc_a: assert property (pslverr |-> acc)
      else $error("stray error");
   err_mis_a: assert property (acc && bad |-> pslverr)
      else $error("no error");
   rd_bad_a: assert property (rs && bad |=> prdata == 0)
      else $error("bad read data");
   clr_rd_a: assert property (cw ##1 (rs && paddr == $past(paddr))
      |=> prdata == 0) else $error("count not cleared");
   rd_back_a: assert property (pw ##1 (rs && paddr == $past(paddr))
      |=> ((prdata ^ $past(pwdata, 2)) & 'hff) == 0) else $error("readback");
   oe_src_a: assert property ($changed(pwm_oe_n)
      |-> $past(ew) || $past(ew, 2)) else $error("drive moved");
   // Four quiet cycles cover the enable resync chain
   quiet_out_a: assert property ((!wr && chan_tick == 0) [*4]
      |=> $stable(pwm_out)) else $error("output moved");
   cover property (cw);
   cover property (pslverr);
   cover property ($changed(pwm_out));
endmodule // pwmc_core_chk
bind pwmc_core pwmc_core_chk #(.ADDR_W(ADDR_W), .NCH(NCH)) pwmc_core_chk_inst
(
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .chan_tick(chan_tick),
   .pwm_out(pwm_out), .pwm_oe_n(pwm_oe_n)
);

// [tb/pwmc_core_tb.sv]
/* Bench for the PWM core with an integer model of count and waveform.
   Assumes a zero-wait APB slave. */
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fails++; \
   $display("ERROR %0t: got %0h exp %0h", $time, a, b); end end
module pwmc_core_tb;
   // Stimulus and observed ports
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, rd, s = 32'hfc58_8697;
   logic [3:0]  chan_tick = 0;
   logic        er;
   wire  [31:0] prdata;
   wire         pready, pslverr;
   wire  [3:0]  pwm_out, pwm_oe_n;
   int          fails = 0, num_checks = 0, c, p, d, q, n, hi;

   pwmc_core pwmc_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .chan_tick(chan_tick), .pwm_out(pwm_out), .pwm_oe_n(pwm_oe_n));

   // 100 MHz clock
   always #5 pclk = ~pclk;

   // Xorshift source
   function automatic logic [31:0] rnd();
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction

   // High cycles over k periods; boundary values force a fixed level
   function automatic int exp_hi(int p, int d, int q, int k);
      int h;
      h = p == 0 ? 0 : d == 0 ? p + 1 : d >= p ? 0 : p + 1 - d;
      return q ? (p + 1 - h) * k : h * k;
   endfunction

   // One transfer; b keeps the bus so the next setup follows at once
   task apb(input logic w, input logic [11:0] a, input logic [31:0] v,
            input logic b = 0);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= v;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      if (!b)
      begin
         psel <= 0;
         penable <= 0;
         @(posedge pclk);
      end
   endtask

   // Verdict
   task end_sim;
      if (fails == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // Hang guard, far beyond the expected run
   initial
   begin
      #400_000;
      fails++;
      end_sim;
   end

   // Reset values, unmapped access, then random channel trials
   initial
   begin
      repeat (6) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      for (c = 'h64; c < 'h70; c++)
      begin
         apb(0, 12'(c * 4), 0);
         `CHK(rd[7:0], c < 'h68 ? 8'h00 : 8'hff)
      end
      apb(0, 12'h1c0, 0);
      `CHK({er, rd}, 33'h1_0000_0000)
      apb(0, 12'h192, 0);
      `CHK({er, rd}, 33'h1_0000_0000)
      for (n = 0; n < 8; n++)
      begin
         c = rnd() % 4;
         q = rnd() % 2;
         p = n == 0 ? 0 : rnd() % 40;
         d = n == 1 ? 0 : n == 2 ? p + rnd() % 3 : rnd() % 40;
         apb(1, 12'h184, q << c);
         apb(1, 12'(12'h1a0 + 4 * c), p);
         apb(1, 12'h18c, 1 << c);
         apb(1, 12'(12'h1b0 + 4 * c), d, 1);
         apb(0, 12'(12'h1b0 + 4 * c), 0);
         `CHK(rd[7:0], 8'(d))
         apb(1, 12'(12'h190 + 4 * c), rnd(), 1);
         apb(0, 12'(12'h190 + 4 * c), 0);
         `CHK(rd[7:0], 8'h00)
         // Whole periods only, so the phase of the window cancels out
         chan_tick <= 4'hf;
         repeat (2 * p + 6) @(posedge pclk);
         hi = 0;
         repeat (4 * p + 4)
         begin
            @(posedge pclk);
            hi += pwm_out[c];
         end
         `CHK(hi, exp_hi(p, d, q, 4))
         `CHK(pwm_oe_n, ~(4'h1 << c))
         chan_tick <= 4'h0;
         apb(1, 12'(12'h190 + 4 * c), 0);
         chan_tick[c] <= 1'b1;
         repeat (p + 3) @(posedge pclk);
         chan_tick <= 4'h0;
         repeat (2)
         begin
            apb(0, 12'(12'h190 + 4 * c), 0);
            `CHK(rd[7:0], 8'((p + 3) % (p + 1)))
         end
      end
      end_sim;
   end
endmodule // pwmc_core_tb
